/* hw/adc_event_packet_builder.sv */
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ns
`include "evb_defs.svh"
// Contract
// - type code sits in top nibble
// - header first, type 8, trigger number
// - misplaced first packet becomes header-error 9
// - two timestamp packets split 48 bits
// - timestamp advances every sampling clock
// - channel identity packet, channel in 2:0
// - group number in bits 6:3
// - raw packets, second sample at bit 14
// - timing packet precedes charge packet
// - clipped peak, 50 percent interpolated crossing
// - charge packet precedes trailer
// - trailer type E, trigger, bit 28 flag
// - misplaced packet emits error packet F
// - readable count of available packets
// - all packets read from one address
// - control bit 0 runs acquisition
// - deconvolution FIR scaled by M
// - baseline tracks only without pulse
// - boxcar sum, charge sampled after peak
// - charge is K times M times signal/128
// - trailer trigger equals header trigger
// - suppression drops channels without hit
module adc_event_packet_builder import evb_pkg::*; #(
  parameter int NCH = 8,
  parameter int GROUP_ID = 0,
  parameter int SEG = 8,
  parameter int L_WIN = 8,
  parameter int K_BOX = 4,
  parameter int PH = 8,
  parameter int DEPTH = 64,
  parameter logic [15:0] M_DECAY = 16'h0010,
  parameter logic [7:0] CHG_DLY = 8'h02
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic TRIG_IN,
  input wire logic [NCH*10-1:0] ADC_DATA,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic BUSY
);
  localparam int SW = $clog2(SEG);
  localparam int CW = $clog2(NCH);
  localparam int AW = $clog2(DEPTH);

  // *****************************
  // configuration checks
  // *****************************
  // odd or empty segments would split a sample pair
  if (SEG < 2 || SEG % 2 != 0 || NCH < 2 || NCH > 8 || GROUP_ID > 5 || L_WIN < 3 || PH < 2 || K_BOX < 1
      || DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : bad_cfg
    $error("adc_event_packet_builder: unsupported parameters");
  end

  typedef struct packed {
    phase_e ph;
    logic trig_s1;
    logic trig_s2;
    logic trig_p;
    logic [NCH-1:0][9:0] adc1;
    logic [NCH-1:0][9:0] adc2;
    logic [47:0] ts;
    logic [47:0] ts_lat;
    logic [23:0] trig_no;
    logic [3:0] ctl;
    logic [9:0] thr;
    logic [SW-1:0] scnt;
    logic [CW-1:0] ch;
    logic [NCH-1:0][L_WIN-1:0][9:0] dline;
    logic [NCH-1:0][31:0] sum;
    logic [NCH-1:0][31:0] bl;
    logic [NCH-1:0][31:0] box;
    logic [NCH-1:0][K_BOX-1:0][31:0] bdl;
    logic [NCH-1:0][PH-1:0][10:0] chist;
    logic [NCH-1:0][10:0] peak;
    logic [NCH-1:0] hit;
    logic [NCH-1:0] tdone;
    logic [NCH-1:0] cpend;
    logic [NCH-1:0][7:0] cdly;
    logic [NCH-1:0][15:0] tim;
    logic [NCH-1:0][31:0] chg;
    logic [NCH-1:0][SEG-1:0][9:0] raw;
    logic [DEPTH-1:0][31:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [3:0] last;
    logic oos;
    logic wq;
    logic [31:0] rdata;
    logic busy;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic emit;
  logic push;
  logic bad;
  logic [3:0] want;
  logic [31:0] pkt;
  logic [31:0] word;

  // legal successor of the last packet type
  function automatic logic seq_ok(input logic [3:0] prev, input logic [3:0] cur);
    case (cur)
      `TYPE_HDR: seq_ok = (prev == `TYPE_TRL);
      `TYPE_TS: seq_ok = (prev == `TYPE_HDR) || (prev == `TYPE_TS);
      `TYPE_CHID: seq_ok = (prev != `TYPE_HDR) && (prev != `TYPE_TRL);
      `TYPE_RAW: seq_ok = (prev == `TYPE_CHID) || (prev == `TYPE_RAW);
      `TYPE_TIME: seq_ok = (prev == `TYPE_RAW);
      `TYPE_CHG: seq_ok = (prev == `TYPE_RAW) || (prev == `TYPE_TIME);
      default: seq_ok = (prev != `TYPE_HDR) && (prev != `TYPE_TRL);
    endcase
  endfunction

  // *****************************
  // next state
  // *****************************
  always_comb begin
    logic [9:0] smp;
    logic signed [10:0] clip;
    logic signed [31:0] f;
    logic signed [31:0] corr;
    logic signed [31:0] mdec;
    logic signed [11:0] half, hi, lo;
    logic signed [15:0] num, den, tcalc;
    logic last_ch;
    logic skip;
    int ri;
    // every scratch value starts defined so no path leaves a latch behind
    smp = '0;
    clip = '0;
    f = '0;
    corr = '0;
    half = '0;
    hi = '0;
    lo = '0;
    num = '0;
    den = '0;
    tcalc = '0;
    st_d = st_q;
    emit = 1'b0;
    want = `TYPE_RAW;
    word = 32'h0000_0000;
    skip = 1'b0;
    last_ch = (st_q.ch == CW'(NCH - 1));
    mdec = 32'(M_DECAY);
    ri = 2 * int'(st_q.scnt);
    // trigger and adc pins pass two flops before use
    st_d.trig_s1 = TRIG_IN;
    st_d.trig_s2 = st_q.trig_s1;
    st_d.trig_p = st_q.trig_s2;
    st_d.adc1 = ADC_DATA;
    st_d.adc2 = st_q.adc1;
    st_d.ts = st_q.ts + 48'h1;
    st_d.busy = (st_q.ph != S_IDLE);

    // per-channel filters run continuously
    for (int c = 0; c < NCH; c++) begin
      smp = st_q.adc2[c];
      clip = $signed({1'b0, smp}) - $signed({1'b0, st_q.dline[c][`CLIP_TAP]});
      f = mdec * (32'(smp) - 32'(st_q.dline[c][L_WIN-1])) + $signed(st_q.sum[c]);
      st_d.sum[c] = st_q.sum[c] + 32'(smp) - 32'(st_q.dline[c][L_WIN-1]);
      st_d.dline[c] = {st_q.dline[c][L_WIN-2:0], smp};
      if (clip <= $signed({1'b0, st_q.thr})) begin
        st_d.bl[c] = 32'($signed(st_q.bl[c]) + ((f - $signed(st_q.bl[c])) >>> `BLR_SHIFT));
      end
      corr = f - $signed(st_q.bl[c]);
      st_d.box[c] = st_q.box[c] + 32'(corr) - st_q.bdl[c][K_BOX-1];
      st_d.bdl[c] = {st_q.bdl[c][K_BOX-2:0], 32'(corr)};
      st_d.chist[c] = {st_q.chist[c][PH-2:0], clip};
      if (st_q.ph == S_CAPT) begin
        st_d.raw[c][st_q.scnt] = smp;
        if (clip > $signed({1'b0, st_q.thr})) begin
          st_d.hit[c] = 1'b1;
          if (clip > $signed(st_q.peak[c])) begin
            st_d.peak[c] = clip;
          end
        end
        // peak passed: search history for the half-height crossing
        if (st_q.hit[c] && !st_q.tdone[c] && clip < $signed(st_q.peak[c])) begin
          half = $signed({st_q.peak[c][10], st_q.peak[c]}) >>> 1;
          tcalc = 16'sh0000;
          for (int j = PH - 1; j > 0; j--) begin
            lo = $signed({st_q.chist[c][j][10], st_q.chist[c][j]});
            hi = $signed({st_q.chist[c][j-1][10], st_q.chist[c][j-1]});
            if (lo < half && hi >= half) begin
              num = 16'(half - lo) * `FRAC_STEPS;
              den = 16'(hi - lo);
              tcalc = 16'($signed({1'b0, st_q.scnt}) - 16'sh0001 - 16'(j)) <<< `FRAC_SHIFT;
              tcalc = tcalc + num / den;
            end
          end
          st_d.tim[c] = 16'(tcalc);
          st_d.tdone[c] = 1'b1;
          st_d.cpend[c] = 1'b1;
          st_d.cdly[c] = CHG_DLY;
        end
        // charge taken a fixed time after the peak has passed
        if (st_q.cpend[c]) begin
          if (st_q.cdly[c] == 8'h00) begin
            st_d.chg[c] = 32'($signed(st_q.box[c]) >>> `CHG_SHIFT);
            st_d.cpend[c] = 1'b0;
          end else begin
            st_d.cdly[c] = st_q.cdly[c] - 8'h01;
          end
        end
      end
    end

    // packet sequencer
    unique case (st_q.ph)
      S_IDLE: begin
        if (st_q.ctl[`CSR_RUN] && st_q.trig_s2 && !st_q.trig_p) begin
          st_d.ph = S_CAPT;
          st_d.ts_lat = st_q.ts;
          st_d.scnt = '0;
          st_d.hit = '0;
          st_d.tdone = '0;
          st_d.cpend = '0;
          st_d.peak = '0;
          st_d.tim = '0;
          st_d.chg = '0;
        end
      end
      S_CAPT: begin
        st_d.scnt = st_q.scnt + SW'(1);
        if (st_q.scnt == SW'(SEG - 1)) begin
          st_d.ph = S_HDR;
          st_d.ch = '0;
        end
      end
      S_HDR: begin
        emit = 1'b1;
        want = `TYPE_HDR;
        word = {`TYPE_HDR, 4'h0, st_q.trig_no};
      end
      S_TS1: begin
        emit = 1'b1;
        want = `TYPE_TS;
        word = {`TYPE_TS, 4'h0, st_q.ts_lat[47:`TS_SPLIT]};
      end
      S_TS2: begin
        emit = 1'b1;
        want = `TYPE_TS;
        word = {`TYPE_TS, 4'h0, st_q.ts_lat[`TS_SPLIT-1:0]};
      end
      S_CHID: begin
        skip = st_q.ctl[`CSR_SUPP] && !st_q.hit[st_q.ch];
        emit = !skip;
        want = `TYPE_CHID;
        word = {`TYPE_CHID, 21'h0, 4'(GROUP_ID), 3'(st_q.ch)};
      end
      S_RAW: begin
        emit = 1'b1;
        want = `TYPE_RAW;
        word = {`TYPE_RAW, 4'h0, st_q.raw[st_q.ch][ri+1], 4'h0, st_q.raw[st_q.ch][ri]};
      end
      S_TIME: begin
        emit = 1'b1;
        want = `TYPE_TIME;
        word = {`TYPE_TIME, 12'h000, st_q.tim[st_q.ch]};
      end
      S_CHG: begin
        emit = 1'b1;
        want = `TYPE_CHG;
        word = {`TYPE_CHG, st_q.chg[st_q.ch][27:0]};
      end
      S_TRL: begin
        emit = 1'b1;
        want = `TYPE_TRL;
        word = {`TYPE_TRL, 4'h0, st_q.trig_no};
        word[`OOS_BIT] = st_q.oos;
      end
    endcase

    // out-of-place packets are replaced by an error word
    bad = emit && !seq_ok(st_q.last, want);
    pkt = word;
    if (bad) begin
      pkt = {((want == `TYPE_HDR) ? `TYPE_HERR : `TYPE_ERR), 4'h0, st_q.trig_no};
    end
    push = emit && (st_q.cnt != (AW + 1)'(DEPTH));

    // advance on push; a full buffer stalls the sequencer
    if (push || skip) begin
      if (push) begin
        st_d.mem[st_q.wp] = pkt;
        st_d.wp = st_q.wp + AW'(1);
        st_d.last = want;
        st_d.oos = st_q.oos | bad;
      end
      unique case (st_q.ph)
        S_HDR: st_d.ph = S_TS1;
        S_TS1: st_d.ph = S_TS2;
        S_TS2: st_d.ph = S_CHID;
        S_CHID: begin
          st_d.scnt = '0;
          if (skip) begin
            st_d.ph = last_ch ? S_TRL : S_CHID;
            st_d.ch = st_q.ch + CW'(1);
          end else begin
            st_d.ph = S_RAW;
          end
        end
        S_RAW: begin
          st_d.scnt = st_q.scnt + SW'(1);
          if (int'(st_q.scnt) == SEG / 2 - 1) begin
            st_d.ph = !st_q.ctl[`CSR_NOTIME] ? S_TIME : !st_q.ctl[`CSR_NOCHG] ? S_CHG : last_ch ? S_TRL : S_CHID;
            st_d.ch = (st_q.ctl[`CSR_NOTIME] && st_q.ctl[`CSR_NOCHG]) ? st_q.ch + CW'(1) : st_q.ch;
          end
        end
        S_TIME: begin
          st_d.ph = !st_q.ctl[`CSR_NOCHG] ? S_CHG : last_ch ? S_TRL : S_CHID;
          st_d.ch = st_q.ctl[`CSR_NOCHG] ? st_q.ch + CW'(1) : st_q.ch;
        end
        S_CHG: begin
          st_d.ph = last_ch ? S_TRL : S_CHID;
          st_d.ch = st_q.ch + CW'(1);
        end
        S_TRL: begin
          st_d.ph = S_IDLE;
          st_d.trig_no = st_q.trig_no + 24'h1;
          st_d.oos = 1'b0;
        end
        default: st_d.ph = st_q.ph;
      endcase
    end

    // avalon slave: one wait cycle, answer on the next edge
    st_d.wq = 1'b1;
    if ((AVS_READ || AVS_WRITE) && st_q.wq) begin
      st_d.wq = 1'b0;
      unique case (AVS_ADDRESS)
        `OFS_CSR: st_d.rdata = {23'h0, st_q.busy, 4'h0, st_q.ctl};
        `OFS_COUNT: st_d.rdata = 32'(st_q.cnt);
        `OFS_DATA: st_d.rdata = (st_q.cnt != '0) ? st_q.mem[st_q.rp] : 32'h0000_0000;
        `OFS_THR: st_d.rdata = {22'h0, st_q.thr};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    // writes and pops take effect where waitrequest is seen low
    if (!st_q.wq && AVS_WRITE) begin
      if (AVS_ADDRESS == `OFS_CSR) begin
        st_d.ctl = AVS_WRITEDATA[3:0];
      end
      if (AVS_ADDRESS == `OFS_THR) begin
        st_d.thr = AVS_WRITEDATA[9:0];
      end
    end
    if (!st_q.wq && AVS_READ && AVS_ADDRESS == `OFS_DATA && st_q.cnt != '0) begin
      st_d.rp = st_q.rp + AW'(1);
      st_d.cnt = st_q.cnt - (AW + 1)'(1) + (AW + 1)'(push);
    end else begin
      st_d.cnt = st_q.cnt + (AW + 1)'(push);
    end
  end

  // *****************************
  // state register
  // *****************************
  // clock enable freezes everything, bus included
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= '0;
      st_q.last <= `TYPE_TRL;
      st_q.wq <= 1'b1;
      st_q.thr <= `THR_RST;
    end else if (CE) begin
      st_q <= st_d;
    end
  end

  assign AVS_READDATA = st_q.rdata;
  assign AVS_WAITREQUEST = st_q.wq;
  assign BUSY = st_q.busy;

  // *****************************
  // checks
  // *****************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  hdr_word_a: assert property (CE && push && !bad && st_q.ph == S_HDR |->
    pkt[31:28] == `TYPE_HDR && pkt[23:0] == st_q.trig_no) else $error("header word wrong");
  ts_split_a: assert property (CE && push && st_q.ph == S_TS1 && !bad |=>
    st_q.mem[$past(st_q.wp)][23:0] == st_q.ts_lat[47:24]) else $error("timestamp high half wrong");
  ts_step_a: assert property (CE ##1 CE |-> st_q.ts == $past(st_q.ts) + 48'h1) else $error("timestamp step");
  raw_zero_a: assert property (push && st_q.ph == S_RAW |->
    pkt[31:24] == 8'h00 && pkt[13:10] == 4'h0) else $error("raw packet spare bits set");
  trl_trig_a: assert property (push && st_q.ph == S_TRL |->
    pkt[23:0] == st_q.trig_no && pkt[28] == (st_q.oos | bad)) else $error("trailer word wrong");
  herr_word_a: assert property (push && bad && want == `TYPE_HDR |->
    pkt[31:28] == `TYPE_HERR) else $error("header error not flagged");
  count_read_a: assert property (CE && AVS_READ && st_q.wq && AVS_ADDRESS == `OFS_COUNT ##1 CE |->
    !AVS_WAITREQUEST && AVS_READDATA == 32'($past(st_q.cnt))) else $error("count read wrong");
  run_stop_a: assert property (st_q.ph == S_IDLE && !st_q.ctl[`CSR_RUN] |=>
    st_q.ph == S_IDLE) else $error("event started while stopped");
endmodule

/* hw/evb_defs.svh */
`ifndef EVB_DEFS_SVH
`define EVB_DEFS_SVH
// packet type nibbles, bits 31:28
`define TYPE_MSB 31
`define TYPE_LSB 28
`define TYPE_RAW 4'h0
`define TYPE_TIME 4'h4
`define TYPE_CHG 4'h5
`define TYPE_HDR 4'h8
`define TYPE_HERR 4'h9
`define TYPE_TS 4'ha
`define TYPE_CHID 4'hc
`define TYPE_TRL 4'he
`define TYPE_ERR 4'hf
// packet fields
`define TRIG_MSB 23
`define TS_SPLIT 24
`define RAW_S1_LSB 14
`define OOS_BIT 28
`define CHG_SHIFT 7
`define CLIP_TAP 2
`define FRAC_STEPS 16'sh0010
`define FRAC_SHIFT 4
`define BLR_SHIFT 4
// register byte offsets
`define OFS_CSR 8'h00
`define OFS_COUNT 8'h04
`define OFS_DATA 8'h08
`define OFS_THR 8'h0c
// control word bits
`define CSR_RUN 0
`define CSR_SUPP 1
`define CSR_NOTIME 2
`define CSR_NOCHG 3
`define CSR_BUSY 8
`define THR_RST 10'h020
`endif

/* hw/evb_pkg.sv */
package evb_pkg;
  // builder phases
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_CAPT = 4'h1,
    S_HDR = 4'h2,
    S_TS1 = 4'h3,
    S_TS2 = 4'h4,
    S_CHID = 4'h5,
    S_RAW = 4'h6,
    S_TIME = 4'h7,
    S_CHG = 4'h8,
    S_TRL = 4'h9
  } phase_e;
  typedef logic [9:0] sample_t;
endpackage

/* testbench/adc_event_packet_builder_bench.sv */
`timescale 1ns/1ns
`include "evb_defs.svh"
module adc_event_packet_builder_bench import evb_pkg::*;;
  localparam int NCH = 8;
  localparam int SEG = 8;
  logic clk_sys = 1'b0;
  logic ce;
  logic rst_n;
  logic trig_in;
  logic [NCH*10-1:0] adc_data;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic busy;
  logic go;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // ****************
  // clock, dut, reader
  // ****************
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  adc_event_packet_builder #(.NCH(NCH), .SEG(SEG)) adc_event_packet_builder_inst (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce), .TRIG_IN(trig_in), .ADC_DATA(adc_data),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .BUSY(busy)
  );

  avalon_reader_model avalon_reader_model_inst (
    .clk(clk_sys), .rst_n(rst_n), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
    .done(done), .rdata(rdata), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata)
  );

  // ****************
  // shared tasks
  // ****************
  task automatic finish_test;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // a generous ceiling: the whole run needs about a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      finish_test;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    go <= 1'b0;
    while (done !== 1'b1) @(posedge clk_sys);
  endtask

  task automatic pulse_trigger(output int t);
    @(posedge clk_sys);
    trig_in <= 1'b1;
    t = cycles;
    repeat (2) @(posedge clk_sys);
    trig_in <= 1'b0;
  endtask

  task automatic wait_event;
    while (busy !== 1'b1) @(posedge clk_sys);
    while (busy !== 1'b0) @(posedge clk_sys);
  endtask

  // walks one event in fifo order; channel c carries the constant 16*c+3
  task automatic read_event(input logic [23:0] trig, input int nch, output logic [47:0] ts);
    int n;
    int c;
    int p;
    logic [9:0] v;
    n = 4 + nch * (3 + SEG / 2);
    bus(1'b0, `OFS_COUNT, 32'h0);
    check("count", rdata, 32'(n));
    for (int i = 0; i < n; i++) begin
      bus(1'b0, `OFS_DATA, 32'h0);
      c = (i - 3) / (3 + SEG / 2);
      p = (i - 3) % (3 + SEG / 2);
      v = 10'(16 * c + 3);
      // an error word would force the reader to throw the event away
      check("error word", {31'h0, rdata[31:28] == `TYPE_ERR || rdata[31:28] == `TYPE_HERR}, 32'h0);
      if (i == 0) begin
        check("header", rdata, {`TYPE_HDR, 4'h0, trig});
      end else if (i < 3) begin
        check("ts type", {28'h0, rdata[31:28]}, {28'h0, `TYPE_TS});
        if (i == 1) ts[47:24] = rdata[23:0];
        else ts[23:0] = rdata[23:0];
      end else if (i == n - 1) begin
        check("trailer", rdata, {`TYPE_TRL, 4'h0, trig});
      end else if (p == 0) begin
        check("chan id", rdata, {`TYPE_CHID, 25'h0, 3'(c)});
      end else if (p <= SEG / 2) begin
        check("raw", rdata, {8'h0, v, 4'h0, v});
      end else if (p == SEG / 2 + 1) begin
        check("time type", {28'h0, rdata[31:28]}, {28'h0, `TYPE_TIME});
      end else begin
        check("charge type", {28'h0, rdata[31:28]}, {28'h0, `TYPE_CHG});
      end
    end
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic test_reset_regs;
    bus(1'b0, `OFS_CSR, 32'h0);
    check("control", rdata, 32'h0);
    bus(1'b0, `OFS_THR, 32'h0);
    check("threshold", rdata, {22'h0, `THR_RST});
    bus(1'b0, `OFS_COUNT, 32'h0);
    check("count", rdata, 32'h0);
    bus(1'b0, `OFS_DATA, 32'h0);
    check("empty data", rdata, 32'h0);
    bus(1'b1, 8'h10, 32'hffffffff);
    bus(1'b0, 8'h10, 32'h0);
    check("unmapped", rdata, 32'h0);
  endtask

  // with run clear neither the stop path nor a trigger may add packets
  task automatic test_stopped(input logic [31:0] ctl);
    int t;
    bus(1'b1, `OFS_CSR, ctl);
    pulse_trigger(t);
    repeat (40) @(posedge clk_sys);
    check("busy stopped", {31'h0, busy}, 32'h0);
    bus(1'b0, `OFS_COUNT, 32'h0);
    check("count stopped", rdata, 32'h0);
  endtask

  // two full events; the second sees a stray trigger while busy
  task automatic test_full_events;
    int ta;
    int tb;
    int tx;
    logic [47:0] tsa;
    logic [47:0] tsb;
    bus(1'b1, `OFS_CSR, 32'h1);
    bus(1'b0, `OFS_CSR, 32'h0);
    check("control run", rdata, 32'h1);
    pulse_trigger(ta);
    wait_event();
    read_event(24'h0, NCH, tsa);
    pulse_trigger(tb);
    while (busy !== 1'b1) @(posedge clk_sys);
    pulse_trigger(tx);
    wait_event();
    read_event(24'h1, NCH, tsb);
    check("ts step", 32'(tsb - tsa), 32'(tb - ta));
  endtask

  // no channel crosses the threshold, so all sub-events vanish
  task automatic test_suppressed;
    int t;
    logic [47:0] ts;
    bus(1'b1, `OFS_CSR, 32'h3);
    pulse_trigger(t);
    wait_event();
    read_event(24'h2, 0, ts);
  endtask

  // a trigger seen only while the clock enable is low must leave no trace
  task automatic test_clock_enable;
    int t;
    bus(1'b1, `OFS_CSR, 32'h1);
    @(posedge clk_sys);
    ce <= 1'b0;
    pulse_trigger(t);
    repeat (20) @(posedge clk_sys);
    check("busy frozen", {31'h0, busy}, 32'h0);
    ce <= 1'b1;
    repeat (20) @(posedge clk_sys);
    check("busy after enable", {31'h0, busy}, 32'h0);
    bus(1'b0, `OFS_COUNT, 32'h0);
    check("count frozen", rdata, 32'h0);
    bus(1'b1, `OFS_CSR, 32'h0);
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    trig_in = 1'b0;
    go = 1'b0;
    wr = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    for (int c = 0; c < NCH; c++) adc_data[c*10 +: 10] = 10'(16 * c + 3);
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_reset_regs();
    test_stopped(32'h0);
    test_full_events();
    test_suppressed();
    test_clock_enable();
    test_stopped(32'h0);
    finish_test;
  end
endmodule

/* testbench/avalon_reader_model.sv */
`timescale 1ns/1ns
// ************************************************
// bus reader standing at the far side of the block
// ************************************************
module avalon_reader_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  output logic done,
  output logic [31:0] rdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata
);
  // one access per go; request held until waitrequest is seen low, then released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      rdata <= 32'h0;
      avs_address <= 8'h0;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= 32'h0;
    end else if (avs_read || avs_write) begin
      if (!avs_waitrequest) begin
        rdata <= avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        done <= 1'b1;
        // released lines flip so a stale value cannot pass for a live one
        avs_address <= ~avs_address;
        avs_writedata <= ~avs_writedata;
      end
    end else begin
      done <= 1'b0;
      if (go) begin
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_read <= !wr;
        avs_write <= wr;
      end
    end
  end
endmodule
